// >>> lsm_agu.sv
// AHB-Lite controlled address generator for load/store-multiple transfers
//
// Decided for this implementation: the AHB-Lite register port and the placing of the registers.
`timescale 1ns/1ps
module lsm_agu
	import lsm_pkg::*;
(
	// Clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// AHB-Lite slave
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	// Data memory side
	output mem_req_t mem_req,
	input wire logic mem_ready,
	input wire mem_rsp_t mem_rsp,
	// Register file write port for loaded values
	output logic rf_we,
	output logic [3:0] rf_waddr,
	output logic [31:0] rf_wdata,
	// Store data read port
	output logic [3:0] rf_raddr,
	input wire logic [31:0] rf_rdata
);
	typedef enum logic [1:0] {S_IDLE, S_ISSUE, S_WAIT} state_t;

	state_t state_r;
	logic [31:0] cmd_r;
	logic [31:0] base_r;
	logic [15:0] list_r;
	logic [31:0] offset_r;
	logic [31:0] pc_r;
	logic [31:0] result_r;
	logic [31:0] newbase_r;
	logic [31:0] branch_r;
	logic busy_r, done_r, rej_r, branch_f_r, tstate_r;
	logic [15:0] remain_r;
	logic [31:0] addr_r;
	logic [3:0] cur_r;
	logic [3:0] slot_r; // second target for the two-word load
	logic ph_r;
	logic [7:0] ph_addr_r;
	logic ph_write_r;
	logic [31:0] ext_w;
	logic [31:0] cmd_w;
	logic [31:0] final_base;
	logic wb_en;

	op_t op;
	logic wr_ph, rd_ph, go;
	logic is_incr, is_load, is_single, is_double, is_stack;
	logic [4:0] count;
	logic signed [31:0] sofs;

	// Count of registers in a list
	function automatic logic [4:0] popcount(input logic [15:0] l);
		logic [4:0] n;
		n = 5'h00;
		for (int i = 0; i < 16; i++)
			n = n + {4'h0, l[i]};
		return n;
	endfunction

	// Lowest set bit index
	function automatic logic [3:0] lowest(input logic [15:0] l);
		logic [3:0] n;
		n = 4'h0;
		for (int i = 15; i >= 0; i--)
			if (l[i])
				n = 4'(i);
		return n;
	endfunction

	// Highest set bit index
	function automatic logic [3:0] highest(input logic [15:0] l);
		logic [3:0] n;
		n = 4'h0;
		for (int i = 0; i < 16; i++)
			if (l[i])
				n = 4'(i);
		return n;
	endfunction

	// Byte span of a register count
	function automatic logic [31:0] span(input logic [4:0] n);
		return {25'h0000000, n, 2'b00};
	endfunction

	// Command decode; aliases fold onto the same mode
	always_comb
	begin
		op = op_t'(cmd_w[CMD_OP_LSB +: 4]);
		is_single = (op == OP_SINGLE_LOAD);
		is_double = (op == OP_DOUBLE_LOAD);
		is_stack = 1'b0;
		is_incr = 1'b1;
		is_load = 1'b1;
		case (op)
			OP_BLOCK_LOAD_IA, OP_FD_POP: is_incr = 1'b1; // RQ11
			OP_BLOCK_LOAD_DB, OP_EA_POP: is_incr = 1'b0; // RQ11
			OP_BLOCK_STORE_IA, OP_EA_PUSH: // RQ11
			begin
				is_load = 1'b0;
			end
			OP_BLOCK_STORE_DB, OP_FD_PUSH: // RQ11
			begin
				is_load = 1'b0;
				is_incr = 1'b0;
			end
			OP_PUSH: // RQ15
			begin
				is_load = 1'b0;
				is_incr = 1'b0;
				is_stack = 1'b1;
			end
			OP_POP: is_stack = 1'b1; // RQ15
			default: is_incr = 1'b1;
		endcase
		count = popcount(list_r);
		sofs = $signed(offset_r);
	end

	// Bus phase decode
	assign wr_ph = ph_r & ph_write_r;
	assign rd_ph = hsel & hready & htrans[1] & ~hwrite;
	assign go = wr_ph & (ph_addr_r == OFS_CMD) & hwdata[CMD_GO_BIT];
	// The command register only lands with the start edge, so decode the
	// incoming word then; a stale op would pick the wrong mode
	assign cmd_w = (go && !busy_r) ? {1'b0, hwdata[30:0]} : cmd_r;
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;

	// Address phase capture
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			ph_r <= 1'b0;
			ph_addr_r <= 8'h00;
			ph_write_r <= 1'b0;
		end
		else if (hready)
		begin
			ph_r <= hsel & htrans[1];
			ph_addr_r <= haddr[7:0];
			ph_write_r <= hwrite;
		end
	end

	// Read data; unmapped addresses read as zero
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			hrdata <= RESET_WORD;
		else if (rd_ph)
		begin
			case (haddr[7:0])
				OFS_CMD: hrdata <= cmd_r;
				OFS_BASE: hrdata <= base_r;
				OFS_LIST: hrdata <= {16'h0000, list_r};
				OFS_STATUS: hrdata <= {27'h0, tstate_r, branch_f_r,
					rej_r, done_r, busy_r};
				OFS_RESULT: hrdata <= result_r;
				OFS_NEWBASE: hrdata <= newbase_r;
				OFS_BRANCH: hrdata <= branch_r;
				OFS_OFFSET: hrdata <= offset_r;
				OFS_PCVAL: hrdata <= pc_r;
				default: hrdata <= RESET_WORD;
			endcase
		end
	end

	// Software-written setup; ignored while a transfer runs
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			cmd_r <= RESET_WORD;
			base_r <= RESET_WORD;
			list_r <= RESET_LIST;
			offset_r <= RESET_WORD;
			pc_r <= RESET_WORD;
		end
		else if (wr_ph && !busy_r)
		begin
			case (ph_addr_r)
				OFS_CMD: cmd_r <= {1'b0, hwdata[30:0]};
				OFS_BASE: base_r <= hwdata;
				OFS_LIST: list_r <= hwdata[15:0];
				OFS_OFFSET: offset_r <= hwdata;
				OFS_PCVAL: pc_r <= hwdata;
				default: cmd_r <= cmd_r;
			endcase
		end
	end

	// Transfer sequencer
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			state_r <= S_IDLE;
			busy_r <= 1'b0;
			done_r <= 1'b0;
			rej_r <= 1'b0;
			branch_f_r <= 1'b0;
			tstate_r <= 1'b1;
			remain_r <= RESET_LIST;
			addr_r <= RESET_WORD;
			cur_r <= 4'h0;
			slot_r <= 4'h0;
			newbase_r <= RESET_WORD;
			branch_r <= RESET_WORD;
			result_r <= RESET_WORD;
		end
		else
		begin
			case (state_r)
				S_IDLE:
				begin
					if (go && !busy_r)
					begin
						done_r <= 1'b0;
						rej_r <= 1'b0;
						branch_f_r <= 1'b0;
						if (is_single &&
							(sofs > SINGLE_OFS_MAX || sofs < -SINGLE_OFS_MAX))
							rej_r <= 1'b1; // RQ2
						else if (is_double &&
							(sofs > DOUBLE_OFS_MAX || sofs < -DOUBLE_OFS_MAX))
							rej_r <= 1'b1; // RQ3
						else if (!is_single && !is_double && count == 5'h00)
							rej_r <= 1'b1; // RQ14
						else
						begin
							busy_r <= 1'b1;
							state_r <= S_ISSUE;
							if (is_single || is_double)
							begin
								addr_r <= pc_r + offset_r;
								cur_r <= list_r[3:0];
								slot_r <= list_r[7:4];
								remain_r <= {15'h0, is_double};
							end
							else if (is_incr)
							begin
								addr_r <= base_r; // RQ8
								cur_r <= lowest(list_r); // RQ8
								remain_r <= list_r;
							end
							else
							begin
								addr_r <= base_r - WORD_STEP; // RQ10 RQ16
								cur_r <= highest(list_r); // RQ10
								remain_r <= list_r;
							end
						end
					end
				end
				S_ISSUE:
				begin
					if (mem_ready)
						state_r <= is_load || is_single || is_double ?
							S_WAIT : S_ISSUE;
					if (mem_ready && !(is_load || is_single || is_double))
					begin
						remain_r[cur_r] <= 1'b0;
						if (remain_r == (16'h0001 << cur_r))
						begin
							state_r <= S_IDLE;
							busy_r <= 1'b0;
							done_r <= 1'b1;
							newbase_r <= final_base; // RQ9 RQ10
						end
						else
						begin
							addr_r <= is_incr ? addr_r + WORD_STEP : // RQ8
								addr_r - WORD_STEP; // RQ10
							cur_r <= is_incr ?
								lowest(remain_r & ~(16'h0001 << cur_r)) :
								highest(remain_r & ~(16'h0001 << cur_r));
						end
					end
				end
				S_WAIT:
				begin
					if (mem_rsp.valid)
					begin
						if (is_single)
						begin
							result_r <= ext_w; // RQ1
							if (cur_r == REG_PC && cmd_r[CMD_SIZE_LSB +: 3] == 3'h0)
							begin
								branch_f_r <= 1'b1; // RQ5
								branch_r <= {mem_rsp.rdata[31:1], 1'b0}; // RQ5
								tstate_r <= mem_rsp.rdata[0]; // RQ5
							end
							state_r <= S_IDLE;
							busy_r <= 1'b0;
							done_r <= 1'b1;
						end
						else if (is_double)
						begin
							result_r <= mem_rsp.rdata;
							if (remain_r[0])
							begin
								remain_r <= RESET_LIST;
								addr_r <= addr_r + WORD_STEP;
								cur_r <= slot_r; // RQ4
								state_r <= S_ISSUE;
							end
							else
							begin
								state_r <= S_IDLE;
								busy_r <= 1'b0;
								done_r <= 1'b1;
							end
						end
						else
						begin
							remain_r[cur_r] <= 1'b0;
							if (cur_r == REG_PC)
							begin
								branch_r <= {mem_rsp.rdata[31:1], 1'b0}; // RQ17
								tstate_r <= mem_rsp.rdata[0]; // RQ17
							end
							if (remain_r == (16'h0001 << cur_r))
							begin
								state_r <= S_IDLE;
								busy_r <= 1'b0;
								done_r <= 1'b1;
								branch_f_r <= list_r[REG_PC]; // RQ17
								newbase_r <= final_base; // RQ9 RQ16
							end
							else
							begin
								state_r <= is_incr ? S_ISSUE : S_ISSUE;
								addr_r <= is_incr ? addr_r + WORD_STEP : // RQ8
									addr_r - WORD_STEP; // RQ10
								cur_r <= is_incr ?
									lowest(remain_r & ~(16'h0001 << cur_r)) :
									highest(remain_r & ~(16'h0001 << cur_r));
							end
						end
					end
				end
				default: state_r <= S_IDLE;
			endcase
		end
	end

	// Base after the transfer; push and pop always write back, and an
	// increment-after block leaves the base on its last word
	always_comb
	begin
		wb_en = is_stack | cmd_r[CMD_WB_BIT]; // RQ15
		if (!wb_en)
			final_base = base_r; // RQ9
		else if (!is_incr)
			final_base = base_r - span(count); // RQ10 RQ16
		else if (is_stack)
			final_base = base_r + span(count); // RQ16
		else
			final_base = base_r + span(count) - WORD_STEP; // RQ9
	end

	// Load data extension
	lsm_extend u_ext
	(
		.raw(mem_rsp.rdata),
		.size(size_t'(cmd_r[CMD_SIZE_LSB +: 3])),
		.lane(addr_r[1:0]),
		.result(ext_w)
	);

	// Memory request; whole-word only for block forms
	always_comb
	begin
		mem_req.valid = (state_r == S_ISSUE); // RQ12
		mem_req.write = ~(is_load || is_single || is_double);
		mem_req.addr = (is_single) ? addr_r : {addr_r[31:2], 2'b00}; // RQ12
		mem_req.wdata = rf_rdata;
		mem_req.regnum = cur_r;
	end
	assign rf_raddr = cur_r;

	// Register file writes; the flags are never a target here
	always_comb
	begin
		rf_we = (state_r == S_WAIT) & mem_rsp.valid & (cur_r != REG_PC); // RQ7
		rf_waddr = cur_r;
		rf_wdata = is_single ? ext_w : mem_rsp.rdata;
	end
endmodule

// >>> lsm_pkg.sv
// Package: constants, types and encodings for the load/store-multiple AGU
// Summary of operation
// RQ1: Extend loaded byte/halfword by size code
// RQ2: Single load offset within -4095 to 4095
// RQ3: Two-word load offset within -1020 to 1020
// RQ4: Second target not stack/program counter, distinct (not checked: list bits 7:4 are used as given)
// RQ5: Word load into program counter branches
// RQ6: Conditional program counter load ends block
// RQ7: Condition flags never modified
// RQ8: Increment-after ascends by four, lowest first
// RQ9: Writeback stores final address, else unchanged
// RQ10: Decrement-before descends, writes back lowest address
// RQ11: Stack aliases map to increment/decrement modes
// RQ12: Block transfers move whole words only
// RQ13: Software avoids illegal base/list combinations
// RQ14: Push/pop list never empty
// RQ15: Push decrement-before store, pop increment-after load
// RQ16: Stack pointer ends at lowest/above highest word
// RQ17: Pop into program counter branches, sets state
// RQ18: Push omits program counter; pop not both (not checked: such lists run as given)
package lsm_pkg;
	// Register bus map (byte addresses)
	localparam logic [7:0] OFS_CMD = 8'h00;
	localparam logic [7:0] OFS_BASE = 8'h04;
	localparam logic [7:0] OFS_LIST = 8'h08;
	localparam logic [7:0] OFS_STATUS = 8'h0C;
	localparam logic [7:0] OFS_RESULT = 8'h10;
	localparam logic [7:0] OFS_NEWBASE = 8'h14;
	localparam logic [7:0] OFS_BRANCH = 8'h18;
	localparam logic [7:0] OFS_OFFSET = 8'h1C;
	localparam logic [7:0] OFS_PCVAL = 8'h20;
	// Command register field positions
	localparam int CMD_OP_LSB = 0;
	localparam int CMD_SIZE_LSB = 4;
	localparam int CMD_WB_BIT = 8;
	localparam int CMD_GO_BIT = 31;
	// Status register field positions
	localparam int ST_BUSY_BIT = 0;
	localparam int ST_DONE_BIT = 1;
	localparam int ST_REJ_BIT = 2;
	localparam int ST_BRANCH_BIT = 3;
	localparam int ST_TSTATE_BIT = 4;
	// Offset limits
	localparam int signed SINGLE_OFS_MAX = 4095;
	localparam int signed DOUBLE_OFS_MAX = 1020;
	localparam logic [31:0] WORD_STEP = 32'h0000_0004;
	localparam logic [3:0] REG_LR = 4'hE;
	localparam logic [3:0] REG_PC = 4'hF;
	localparam logic [31:0] RESET_WORD = 32'h0000_0000;
	localparam logic [15:0] RESET_LIST = 16'h0000;

	// Operations, aliases folded onto the four block modes
	typedef enum logic [3:0]
	{
		OP_SINGLE_LOAD = 4'h0,
		OP_DOUBLE_LOAD = 4'h1,
		OP_BLOCK_LOAD_IA = 4'h2,
		OP_BLOCK_LOAD_DB = 4'h3,
		OP_BLOCK_STORE_IA = 4'h4,
		OP_BLOCK_STORE_DB = 4'h5,
		OP_PUSH = 4'h6,
		OP_POP = 4'h7,
		OP_FD_POP = 4'h8,
		OP_EA_POP = 4'h9,
		OP_EA_PUSH = 4'hA,
		OP_FD_PUSH = 4'hB
	} op_t;

	// Size codes for single loads
	typedef enum logic [2:0]
	{
		SZ_WORD = 3'h0,
		SZ_UBYTE = 3'h1,
		SZ_SBYTE = 3'h2,
		SZ_UHALF = 3'h3,
		SZ_SHALF = 3'h4
	} size_t;

	// Data memory request
	typedef struct packed
	{
		logic valid;
		logic write;
		logic [31:0] addr;
		logic [31:0] wdata;
		logic [3:0] regnum;
	} mem_req_t;

	// Data memory response
	typedef struct packed
	{
		logic valid;
		logic [31:0] rdata;
	} mem_rsp_t;
endpackage

// >>> lsm_extend.sv
// Load data extension by size code
`timescale 1ns/1ps
module lsm_extend
	import lsm_pkg::*;
(
	// Raw word and size
	input wire logic [31:0] raw,
	input wire size_t size,
	input wire logic [1:0] lane,
	// Extended result
	output logic [31:0] result
);
	logic [7:0] byte_v;
	logic [15:0] half_v;

	// Lane select then extend; halfwords use the upper half when lane bit 1 is set, else the lower half
	always_comb
	begin
		byte_v = raw[8*lane +: 8];
		half_v = lane[1] ? raw[31:16] : raw[15:0];
		case (size)
			SZ_UBYTE: result = {24'h000000, byte_v}; // RQ1
			SZ_SBYTE: result = {{24{byte_v[7]}}, byte_v}; // RQ1
			SZ_UHALF: result = {16'h0000, half_v}; // RQ1
			SZ_SHALF: result = {{16{half_v[15]}}, half_v}; // RQ1
			default: result = raw; // RQ1
		endcase
	end
endmodule

// >>> lsm_agu_properties.sv
// Checker for the generator's bus answers and memory-side sequencing
`timescale 1ns/1ps
module lsm_agu_properties
	import lsm_pkg::*;
(
	// Clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// Bus answer
	input wire logic hreadyout,
	input wire logic hresp,
	// Memory side
	input wire mem_req_t mem_req,
	input wire logic mem_ready,
	input wire mem_rsp_t mem_rsp,
	// Register file side
	input wire logic rf_we,
	input wire logic [3:0] rf_waddr,
	input wire logic [3:0] rf_raddr,
	input wire logic [31:0] rf_rdata
);
	default clocking dcb @(posedge hclk);
	endclocking
	default disable iff (!hresetn);
	logic took_st;
	// Store taken this edge; only a request right after it is its successor
	assign took_st = mem_req.valid && mem_ready && mem_req.write;
	chk_bus_ready: assert property (hreadyout)
		else $error("bus ready dropped");
	chk_bus_okay: assert property (!hresp)
		else $error("bus response not okay");
	chk_store_step: assert property (
		$past(took_st) && mem_req.valid && mem_req.write |->
		mem_req.addr - $past(mem_req.addr) inside {32'h4, 32'hFFFF_FFFC})
		else $error("store address step is not one word");
	chk_reg_order: assert property (
		$past(took_st) && mem_req.valid && mem_req.write |->
		(mem_req.addr > $past(mem_req.addr)) ==
		(mem_req.regnum > $past(mem_req.regnum)))
		else $error("register order disagrees with address order");
	chk_store_data: assert property (
		mem_req.valid && mem_req.write |->
		rf_raddr == mem_req.regnum && mem_req.wdata == rf_rdata)
		else $error("store word is not the listed register");
	chk_req_hold: assert property (
		mem_req.valid && !mem_ready |=>
		mem_req.valid && $stable(mem_req.addr) && $stable(mem_req.write))
		else $error("request changed while stalled");
	chk_no_pc_write: assert property (rf_we |-> rf_waddr != REG_PC)
		else $error("program counter load went to register file");
	chk_load_pair: assert property (rf_we |-> mem_rsp.valid)
		else $error("register write without load data");
	// Main scenarios reached
	cover property (mem_req.valid && !mem_ready);
	cover property (took_st);
	cover property (rf_we);
endmodule
bind lsm_agu lsm_agu_properties u_props (.hclk(hclk), .hresetn(hresetn),
	.hreadyout(hreadyout), .hresp(hresp), .mem_req(mem_req),
	.mem_ready(mem_ready), .mem_rsp(mem_rsp), .rf_we(rf_we),
	.rf_waddr(rf_waddr), .rf_raddr(rf_raddr), .rf_rdata(rf_rdata));

// >>> lsm_mem_model.sv
// Data memory partner with random stalls, late answers and an access log
`timescale 1ns/1ps
module lsm_mem_model
	import lsm_pkg::*;
(
	// Clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// Request and answer
	input wire mem_req_t mem_req,
	output logic mem_ready,
	output mem_rsp_t mem_rsp
);
	logic [31:0] log_addr[$];
	logic [31:0] log_data[$];
	logic [3:0] log_reg[$];
	logic [31:0] pend;
	int wait_n;
	// Read contents are a pattern of the request byte address
	function automatic logic [31:0] pattern(input logic [31:0] a);
		return {a[15:0], ~a[15:0]};
	endfunction
	initial
	begin
		mem_ready = 1'b0;
		mem_rsp = '0;
		wait_n = -1;
	end
	// Stall at random; load data comes one to three cycles after taking
	always @(posedge hclk)
	begin
		mem_rsp.valid <= 1'b0;
		mem_rsp.rdata <= ~mem_rsp.rdata; // Junk so stale data never matches
		if (wait_n == 0)
		begin
			mem_rsp.valid <= 1'b1;
			mem_rsp.rdata <= pattern(pend);
		end
		if (wait_n >= 0)
			wait_n <= wait_n - 1;
		if (hresetn && mem_req.valid && mem_ready)
		begin
			log_addr.push_back(mem_req.addr);
			log_data.push_back(mem_req.wdata);
			log_reg.push_back(mem_req.regnum);
			if (!mem_req.write)
			begin
				pend <= mem_req.addr;
				wait_n <= $urandom_range(2);
			end
		end
		mem_ready <= ($urandom_range(3) != 0);
	end
endmodule

// >>> lsm_agu_test.sv
// Self-checking bench for the load/store-multiple address generator
`timescale 1ns/1ps
module lsm_agu_test;
	import lsm_pkg::*;
	logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp;
	logic mem_ready, rf_we, asc, wr;
	logic [1:0] htrans;
	logic [2:0] hsize;
	logic [3:0] rf_waddr, rf_raddr;
	logic [15:0] list;
	logic [31:0] haddr, hwdata, hrdata, rf_wdata, rf_rdata, rd, st, base, pc;
	mem_req_t mem_req;
	mem_rsp_t mem_rsp;
	logic [31:0] rf_val[$];
	int failures, num_checks, k, r;
	int lim[8] = '{4095, -4095, 4096, -4096, 1020, -1020, 1021, -1021};
	lsm_agu u_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
		.hwdata(hwdata), .hready(hready), .hrdata(hrdata),
		.hreadyout(hreadyout), .hresp(hresp), .mem_req(mem_req),
		.mem_ready(mem_ready), .mem_rsp(mem_rsp), .rf_we(rf_we),
		.rf_waddr(rf_waddr), .rf_wdata(rf_wdata), .rf_raddr(rf_raddr),
		.rf_rdata(rf_rdata));
	lsm_mem_model u_mem (.hclk(hclk), .hresetn(hresetn), .mem_req(mem_req),
		.mem_ready(mem_ready), .mem_rsp(mem_rsp));
	// Single slave: its ready is the bus ready
	assign hready = hreadyout;
	assign rf_rdata = {16'hC0DE, 12'h000, rf_raddr};
	initial
	begin
		hclk = 1'b0;
		forever #2.5 hclk = ~hclk;
	end
	// Capture loaded values as the register file would take them
	always @(posedge hclk)
		if (rf_we === 1'b1)
			rf_val.push_back(rf_wdata);
	function automatic logic [31:0] ext(input logic [31:0] w, input int sz,
		input logic [1:0] ln);
		logic [7:0] b;
		logic [15:0] h;
		b = w[8*ln +: 8];
		h = w[16*ln[1] +: 16];
		case (sz)
			1: return {24'h0, b};
			2: return {{24{b[7]}}, b};
			3: return {16'h0, h};
			4: return {{16{h[15]}}, h};
			default: return w;
		endcase
	endfunction
	// Base after a block transfer: a pop moves past its last word
	function automatic logic [31:0] end_base(input int op,
		input logic [31:0] b, input int n);
		if (op == 7)
			return b + 4*n;
		if (op inside {2, 4, 8, 10})
			return b + 4*(n-1);
		return b - 4*n;
	endfunction
	task automatic check(input string what, input logic [31:0] seen, exp);
		num_checks++;
		if (seen !== exp)
		begin
			failures++;
			$display("FAIL %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic wrap_up;
		$display("checks %0d failures %0d", num_checks, failures);
		if (failures == 0 && num_checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	// One single word transfer; waits for ready in both phases
	task automatic bus(input logic w, input logic [7:0] a,
		input logic [31:0] d, output logic [31:0] q);
		hsel <= 1'b1;
		htrans <= 2'b10;
		hwrite <= w;
		haddr <= {24'h0, a};
		hsize <= 3'b010;
		do @(posedge hclk); while (hready !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'b00;
		hwdata <= d;
		do @(posedge hclk); while (hready !== 1'b1);
		q = hrdata;
	endtask
	task automatic run(input logic [3:0] op, input logic [2:0] sz,
		input logic [15:0] lst, input logic [31:0] b);
		int n;
		u_mem.log_addr.delete();
		u_mem.log_data.delete();
		u_mem.log_reg.delete();
		rf_val.delete();
		bus(1'b1, OFS_BASE, b, st);
		bus(1'b1, OFS_LIST, {16'h0, lst}, st);
		bus(1'b1, OFS_CMD, {1'b1, 22'h0, 1'b1, 1'b0, sz, op}, st);
		n = 0;
		do
		begin
			bus(1'b0, OFS_STATUS, 32'h0, st);
			n++;
		end
		while (st[ST_DONE_BIT] !== 1'b1 && st[ST_REJ_BIT] !== 1'b1 && n < 100);
		if (n >= 100)
			failures++;
	endtask
	initial
	begin
		{hsel, hwrite, htrans, hsize, haddr, hwdata, hresetn} = '0;
		void'($urandom(35));
		repeat (2) @(posedge hclk);
		hresetn <= 1'b1;
		bus(1'b0, OFS_STATUS, 32'h0, rd);
		check("status reset", rd, 32'h1 << ST_TSTATE_BIT);
		bus(1'b1, 8'h40, 32'hFFFF_FFFF, rd);
		bus(1'b0, OFS_BASE, 32'h0, rd);
		check("base reset", rd, RESET_WORD);
		$display("test reset done");
		// Every block mode and alias with random lists (no SP, no PC)
		for (int op = 2; op < 12; op++)
			repeat (2)
			begin
				list = (16'($urandom) & 16'h5FFF) | 16'h0001;
				base = ($urandom & 32'h00FF_FFF0) | 32'h0000_1000;
				run(4'(op), SZ_WORD, list, base);
				asc = op inside {2, 4, 7, 8, 10};
				wr = op inside {4, 5, 6, 10, 11};
				check("count", u_mem.log_addr.size(), $countones(list));
				k = 0;
				for (int i = 0; i < 16; i++)
				begin
					r = asc ? i : 15 - i;
					if (list[r])
					begin
						check("addr", u_mem.log_addr[k],
							asc ? base + 4*k : base - 4*(k+1));
						check("reg", u_mem.log_reg[k], r);
						if (wr)
							check("data", u_mem.log_data[k],
								{16'hC0DE, 12'h0, 4'(r)});
						else
							check("load", rf_val[k], u_mem.pattern(u_mem.log_addr[k]));
						k++;
					end
				end
				bus(1'b0, OFS_NEWBASE, 32'h0, rd);
				check("newbase", rd, end_base(op, base, k));
			end
		$display("test blocks done");
		// Pop that loads the program counter
		list = (16'($urandom) & 16'h1FFF) | 16'h8001;
		run(4'h7, SZ_WORD, list, 32'h0000_2000);
		pc = u_mem.pattern(u_mem.log_addr[$countones(list) - 1]);
		bus(1'b0, OFS_BRANCH, 32'h0, rd);
		check("branch", {rd[31:1], 1'b0}, {pc[31:1], 1'b0});
		check("taken", st[ST_BRANCH_BIT], 1'b1);
		check("tstate", st[ST_TSTATE_BIT], pc[0]);
		check("rf", rf_val.size(), $countones(list) - 1);
		$display("test pop branch done");
		// Word load straight into the program counter
		bus(1'b1, OFS_PCVAL, 32'h0000_3000, rd);
		bus(1'b1, OFS_OFFSET, 32'h0000_0010, rd);
		run(4'h0, SZ_WORD, 16'h000F, 32'h0);
		pc = u_mem.pattern(32'h0000_3010);
		bus(1'b0, OFS_BRANCH, 32'h0, rd);
		check("ld branch", rd, {pc[31:1], 1'b0});
		check("ld taken", st[ST_BRANCH_BIT], 1'b1);
		check("ld tstate", st[ST_TSTATE_BIT], pc[0]);
		check("ld rf", rf_val.size(), 0);
		$display("test load branch done");
		// Every size code of the single load
		for (int sz = 0; sz < 5; sz++)
		begin
			bus(1'b1, OFS_PCVAL, $urandom & 32'h00FF_FFFC, rd);
			bus(1'b1, OFS_OFFSET, 2 * $urandom_range(2000), rd);
			run(4'h0, 3'(sz), 16'($urandom_range(12)), 32'h0);
			bus(1'b0, OFS_RESULT, 32'h0, rd);
			check("extend", rd, ext(u_mem.pattern(u_mem.log_addr[0]), sz,
				u_mem.log_addr[0][1:0]));
		end
		$display("test sizes done");
		// Offset limits of single and two-word loads
		for (int i = 0; i < 8; i++)
		begin
			bus(1'b1, OFS_PCVAL, 32'h0001_0000, rd);
			bus(1'b1, OFS_OFFSET, lim[i], rd);
			run(i < 4 ? 4'h0 : 4'h1, SZ_WORD, 16'h0021, 32'h0);
			check("reject", st[ST_REJ_BIT], i[1]);
			check("moves", u_mem.log_addr.size(), i[1] ? 0 : (i < 4 ? 1 : 2));
		end
		$display("test limits done");
		wrap_up();
	end
	// Watchdog well beyond the expected run length
	initial
	begin
		#200000;
		failures++;
		wrap_up();
	end
endmodule
